// *** dv/epp_mem_model.sv ***
`timescale 1ns/1ps
module epp_mem_model (
  // Clock
  input wire logic mclk_in,
  // Program side
  input wire logic [31:0] prog_addr_in,
  input wire logic prog_req_in,
  output logic [255:0] prog_data_out,
  // Data side
  input wire logic [31:0] dmem_addr_in,
  input wire logic [31:0] dmem_wdata_in,
  input wire logic dmem_rd_in,
  input wire logic dmem_wr_in,
  output logic [31:0] dmem_rdata_out
);
  logic [31:0] imem [128];
  logic [31:0] dmem [64];
  logic [31:0] rd_addr_reg;
  logic rd_pend_reg;
  // ==========================================================
  // Contents start empty; the bench loads them before reset ends
  initial begin
    foreach (imem[i]) imem[i] = 32'h0000_0000;
    foreach (dmem[i]) dmem[i] = 32'h0000_0000;
    prog_data_out = '0;
    dmem_rdata_out = 32'h5A5A_A5A5;
    rd_addr_reg = 32'h0000_0000;
    rd_pend_reg = 1'b0;
  end
  // Packet for the address seen at this edge; toggles when idle
  always @(posedge mclk_in) begin
    for (int s = 0; s < 8; s++) begin
      if (!prog_req_in) begin
        prog_data_out[32*s +: 32] <= ~prog_data_out[32*s +: 32];
      end else if (prog_addr_in[31:9] != 0) begin
        prog_data_out[32*s +: 32] <= '0;
      end else begin
        prog_data_out[32*s +: 32] <= imem[{prog_addr_in[8:5], s[2:0]}];
      end
    end
  end
  // Read data shows two cycles after the strobe, stale pattern after
  always @(posedge mclk_in) begin
    rd_pend_reg <= dmem_rd_in;
    if (dmem_rd_in) rd_addr_reg <= dmem_addr_in;
    if (rd_pend_reg) dmem_rdata_out <= dmem[rd_addr_reg[7:2]];
    else dmem_rdata_out <= ~dmem_rdata_out;
    if (dmem_wr_in) dmem[dmem_addr_in[7:2]] <= dmem_wdata_in;
  end
endmodule : epp_mem_model

// *** dv/test_epp_pipeline.sv ***
`timescale 1ns/1ps
module test_epp_pipeline;
  import epp_pkg::*;
  logic mclk_in, rst_n_in, sat_clear_in;
  logic [31:0] prog_addr_out, dmem_addr_out, dmem_wdata_out, dmem_rdata_in;
  logic prog_req_out, dmem_rd_out, dmem_wr_out, sat_flag_out;
  logic [255:0] prog_data_in;
  logic [7:0] e1_issue_out;
  logic [15:0] lfsr_reg;
  logic [63:0] wr_q [$];
  logic [63:0] exp_q [$];
  logic [31:0] rd_q [$];
  logic [31:0] a, b;
  int errors, comparisons, lane_cnt;
  // ==========================================================
  // Design and far-side memories
  epp_pipeline i_epp_pipeline (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .prog_addr_out(prog_addr_out), .prog_req_out(prog_req_out),
    .prog_data_in(prog_data_in), .dmem_addr_out(dmem_addr_out),
    .dmem_wdata_out(dmem_wdata_out), .dmem_rd_out(dmem_rd_out),
    .dmem_wr_out(dmem_wr_out), .dmem_rdata_in(dmem_rdata_in),
    .sat_clear_in(sat_clear_in), .sat_flag_out(sat_flag_out),
    .e1_issue_out(e1_issue_out));
  epp_mem_model i_epp_mem_model (.mclk_in(mclk_in),
    .prog_addr_in(prog_addr_out), .prog_req_in(prog_req_out),
    .prog_data_out(prog_data_in), .dmem_addr_in(dmem_addr_out),
    .dmem_wdata_in(dmem_wdata_out), .dmem_rd_in(dmem_rd_out),
    .dmem_wr_in(dmem_wr_out), .dmem_rdata_out(dmem_rdata_in));
  // ==========================================================
  // Clock, 5 ns period
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  function automatic logic [31:0] rnd();
    lfsr_reg = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^
      lfsr_reg[12] ^ lfsr_reg[10]};
    return {lfsr_reg, lfsr_reg ^ 16'hC3A5};
  endfunction : rnd
  function automatic logic [31:0] enc(input int c, z, d, s1, s2, op,
                                      imm, par);
    // Bit 1 of par asks for pointer modify
    return {c[2:0], z[0], d[3:0], s1[3:0], s2[3:0], op[2:0], imm[10:0],
      par[1:0]};
  endfunction : enc
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // Watchdog well past the expected run length
  initial begin
    #(5 * 2000);
    errors++;
    end_sim();
  end
  // Capture memory strobes and lane-three-only issues, mid-cycle
  always @(negedge mclk_in) begin
    if (dmem_wr_out === 1'b1) wr_q.push_back({dmem_addr_out, dmem_wdata_out});
    if (dmem_rd_out === 1'b1) rd_q.push_back(dmem_addr_out);
    if (e1_issue_out === 8'h08) lane_cnt++;
  end
  // ==========================================================
  // Main sequence
  initial begin
    rst_n_in = 1'b0;
    sat_clear_in = 1'b0;
    lfsr_reg = 16'd5836;
    errors = 0;
    comparisons = 0;
    lane_cnt = 0;
    // Let the memory model clear itself before loading it
    #1;
    a = rnd();
    b = rnd();
    i_epp_mem_model.dmem[2] = a;
    i_epp_mem_model.dmem[3] = b;
    i_epp_mem_model.dmem[4] = 32'h7FFF_FFFF;
    i_epp_mem_model.dmem[5] = 32'h0000_0001;
    // Packets 2 to 7 are single parallel groups of no-operations
    for (int i = 16; i < 64; i++) begin
      i_epp_mem_model.imem[i] = (i % 8 == 7) ? 0 : 1;
    end
    for (int i = 0; i < 4; i++) i_epp_mem_model.imem[i] = enc(0, 0, i + 1,
      0, 0, int'(op_load), 8 + 4 * i, 0);
    // Plain multiply of low halves, -1 times 1
    i_epp_mem_model.imem[8] = enc(0, 0, 8, 3, 4, int'(op_mpy), 0, 0);
    i_epp_mem_model.imem[9] = enc(0, 0, 5, 1, 2, int'(op_add), 0, 0);
    i_epp_mem_model.imem[10] = enc(0, 0, 0, 0, 5, int'(op_store), 32, 0);
    i_epp_mem_model.imem[11] = enc(0, 0, 6, 3, 4, int'(op_sadd), 0, 0);
    i_epp_mem_model.imem[12] = enc(0, 0, 0, 0, 6, int'(op_store), 36, 0);
    i_epp_mem_model.imem[13] = enc(7, 0, 0, 0, 1, int'(op_store), 40, 0);
    i_epp_mem_model.imem[14] = enc(7, 1, 0, 0, 2, int'(op_store), 44, 0);
    i_epp_mem_model.imem[15] = enc(0, 0, 0, 0, 0, int'(op_branch), 256, 0);
    // Delay-slot store also moves the base register to 60
    i_epp_mem_model.imem[19] = enc(0, 0, 0, 0, 2, int'(op_store), 60, 3);
    i_epp_mem_model.imem[56] = enc(0, 0, 0, 0, 1, int'(op_store), 56, 0);
    i_epp_mem_model.imem[64] = enc(0, 0, 0, 0, 5, int'(op_store), 48, 0);
    i_epp_mem_model.imem[65] = enc(0, 0, 0, 0, 8, int'(op_store), 52, 0);
    // Model of the expected stores, in program order
    exp_q = '{{32'd32, a + b}, {32'd36, 32'h7FFF_FFFF}, {32'd44, b},
      {32'd60, b}, {32'd108, a + b}, {32'd112, 32'hFFFF_FFFF}};
    repeat (6) @(negedge mclk_in);
    check({31'b0, prog_req_out}, 32'h0000_0000);
    rst_n_in = 1'b1;
    repeat (2) @(negedge mclk_in);
    check({31'b0, prog_req_out}, 32'h0000_0001);
    check(prog_addr_out, 32'h0000_0000);
    check({24'b0, e1_issue_out}, 32'h0000_0000);
    $display("test reset and first fetch done");
    repeat (150) @(negedge mclk_in);
    check(32'(rd_q.size()), 32'd4);
    for (int i = 0; i < 4 && i < rd_q.size(); i++) begin
      check(rd_q[i], 8 + 4 * i);
    end
    $display("test load addresses done");
    check(32'(wr_q.size()), 32'd6);
    for (int i = 0; i < 6 && i < wr_q.size(); i++) begin
      check(wr_q[i][63:32], exp_q[i][63:32]);
      check(wr_q[i][31:0], exp_q[i][31:0]);
    end
    $display("test stores, condition and branch done");
    check(32'(lane_cnt), 32'd3);
    check({31'b0, sat_flag_out}, 32'h0000_0001);
    sat_clear_in = 1'b1;
    @(negedge mclk_in);
    sat_clear_in = 1'b0;
    @(negedge mclk_in);
    check({31'b0, sat_flag_out}, 32'h0000_0000);
    $display("test saturation flag done");
    end_sim();
  end
endmodule : test_epp_pipeline

// *** hw/epp_dispatch.sv ***
`timescale 1ns/1ps
`include "epp_cfg.svh"
module epp_dispatch (
  // Core side
  epp_core_if.disp bus
);
  import epp_pkg::*;

  // ==========================================================
  // Split at the first clear parallel bit from the start slot
  always_comb begin
    logic open;
    epp_dec_t d;
    open = 1'b1;
    d = '0;
    bus.ep_mask = '0;
    bus.route = '0;
    bus.ep_last = 1'b1;
    bus.next_start = '0;
    for (int s = 0; s < 8; s++) begin
      d = epp_decode(bus.pkt[32*s +: 32]);
      if (open && s >= int'(bus.start)) begin
        bus.ep_mask[s] = 1'b1; // RULE4
        bus.route[s] = (d.op != op_nop); // RULE5 RULE7
        if (!bus.pkt[32*s + `EPP_F_PAR]) begin
          open = 1'b0;
          if (s < 7) begin
            bus.ep_last = 1'b0; // RULE24
            bus.next_start = 3'(s + 1);
          end
        end
      end
    end
  end
endmodule : epp_dispatch

// *** hw/epp_pipeline.sv ***
`timescale 1ns/1ps
`include "epp_cfg.svh"
// Operation
// RULE1 - Four fetch phases and two decode phases precede a typed execute run
// RULE2 - Eight instructions fetched together, advancing as one packet
// RULE3 - Address formed, sent, memory read, packet received in order
// RULE4 - Dispatch splits fetch packets into execute packets of one to eight
// RULE5 - Dispatch routes each instruction to its unit for next-phase decode
// RULE6 - Decode yields source, destination and routing selects per unit
// RULE7 - No-operation slots are never routed to a unit
// RULE8 - Five execute phases; each type uses only what it needs
// RULE9 - One packet enters per cycle; all phases move in lockstep
// RULE10 - First execute phase evaluates condition and reads operands
// RULE11 - Load and store address and pointer update in first execute phase
// RULE12 - Branch in first execute phase redirects the generate-phase packet
// RULE13 - Single-cycle results written in first execute phase
// RULE14 - Second execute phase sends address, plus data for stores
// RULE15 - Saturating single-cycle op sets flag in second phase on saturation
// RULE16 - Multiply results written in second execute phase
// RULE17 - Data memory accessed in third execute phase; stores finish there
// RULE18 - Saturating multiply sets flag in third execute phase
// RULE19 - Load data arrives in fourth phase, written in fifth
// RULE20 - False condition: no writes, no activity after first execute phase
// RULE21 - Every processor cycle starts and ends on a clock edge
// RULE22 - No interlocks; dependent instructions never stall
// RULE23 - Branch target executes five cycles after the branch; the code executes it six cycles after, behind five packets
// RULE24 - Several execute packets issue one per cycle; fetch holds meanwhile
// RULE25 - Reset empties every phase; nothing executes before fetch and decode
module epp_pipeline (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Program memory
  output logic [31:0] prog_addr_out,
  output logic prog_req_out,
  input wire logic [255:0] prog_data_in,
  // Data memory
  output logic [31:0] dmem_addr_out,
  output logic [31:0] dmem_wdata_out,
  output logic dmem_rd_out,
  output logic dmem_wr_out,
  input wire logic [31:0] dmem_rdata_in,
  // Status
  input wire logic sat_clear_in,
  output logic sat_flag_out,
  output logic [7:0] e1_issue_out
);
  import epp_pkg::*;

  epp_core_if core ();
  epp_regfile u_rf (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .bus(core.rf));
  epp_dispatch u_dsp (.bus(core.disp));

  // ==========================================================
  // Front end state: fetch, dispatch, decode
  logic pg_vld_reg, pg_vld_next;
  logic [31:0] pc_reg, pc_next, pg_addr;
  logic ps_vld_reg, ps_vld_next;
  logic [31:0] ps_addr_reg, ps_addr_next;
  logic pw_vld_reg, pw_vld_next, pw_fresh_reg, pw_fresh_next;
  logic [255:0] pw_pkt_reg, pw_pkt_next, incoming;
  logic pr_vld_reg, pr_vld_next;
  logic [255:0] pr_pkt_reg, pr_pkt_next;
  logic dp_vld_reg, dp_vld_next;
  logic [255:0] dp_pkt_reg, dp_pkt_next;
  logic [2:0] dp_start_reg, dp_start_next;
  logic [7:0] dc_vld_reg, dc_vld_next, dc_nop;
  logic [255:0] dc_pkt_reg, dc_pkt_next;
  epp_dec_t dc_dec [8];
  logic hold, br_take;
  logic [31:0] br_target;

  // Dispatch works on the packet held in its phase
  assign core.pkt = dp_pkt_reg;
  assign core.start = dp_start_reg;
  assign hold = dp_vld_reg && !core.ep_last; // RULE24

  // Fetch and dispatch next state
  always_comb begin
    incoming = pw_fresh_reg ? prog_data_in : pw_pkt_reg; // RULE3
    pg_addr = br_take ? br_target : pc_reg; // RULE12 RULE23
    pg_vld_next = 1'b1;
    pw_pkt_next = incoming;
    dc_vld_next = dp_vld_reg ? core.route : '0; // RULE5 RULE7
    dc_pkt_next = dp_pkt_reg;
    if (hold) begin
      // Fetch phases freeze; a redirect still lands in generate
      pc_next = pg_addr;
      ps_vld_next = ps_vld_reg;
      ps_addr_next = ps_addr_reg;
      pw_vld_next = pw_vld_reg;
      pw_fresh_next = 1'b0;
      pr_vld_next = pr_vld_reg;
      pr_pkt_next = pr_pkt_reg;
      dp_vld_next = 1'b1;
      dp_pkt_next = dp_pkt_reg;
      dp_start_next = core.next_start; // RULE24
    end else begin
      // Lockstep advance, one phase per cycle
      pc_next = pg_vld_reg ? pg_addr + `EPP_PKT_STEP : pc_reg; // RULE9
      ps_vld_next = pg_vld_reg; // RULE1 RULE2
      ps_addr_next = pg_addr;
      pw_vld_next = ps_vld_reg;
      pw_fresh_next = ps_vld_reg;
      pr_vld_next = pw_vld_reg;
      pr_pkt_next = incoming; // RULE2
      dp_vld_next = pr_vld_reg;
      dp_pkt_next = pr_pkt_reg;
      dp_start_next = '0;
    end
  end

  // Reset empties every phase
  always_ff @(posedge mclk_in or negedge rst_n_in) begin // RULE21
    if (!rst_n_in) begin
      pg_vld_reg <= 1'b0; // RULE25
      pc_reg <= `EPP_RESET_PC;
      ps_vld_reg <= 1'b0;
      ps_addr_reg <= `EPP_RESET_PC;
      pw_vld_reg <= 1'b0;
      pw_fresh_reg <= 1'b0;
      pw_pkt_reg <= '0;
      pr_vld_reg <= 1'b0;
      pr_pkt_reg <= '0;
      dp_vld_reg <= 1'b0;
      dp_pkt_reg <= '0;
      dp_start_reg <= '0;
      dc_vld_reg <= '0;
      dc_pkt_reg <= '0;
    end else begin
      pg_vld_reg <= pg_vld_next;
      pc_reg <= pc_next;
      ps_vld_reg <= ps_vld_next;
      ps_addr_reg <= ps_addr_next;
      pw_vld_reg <= pw_vld_next;
      pw_fresh_reg <= pw_fresh_next;
      pw_pkt_reg <= pw_pkt_next;
      pr_vld_reg <= pr_vld_next;
      pr_pkt_reg <= pr_pkt_next;
      dp_vld_reg <= dp_vld_next;
      dp_pkt_reg <= dp_pkt_next;
      dp_start_reg <= dp_start_next;
      dc_vld_reg <= dc_vld_next;
      dc_pkt_reg <= dc_pkt_next;
    end
  end

  // Decode phase: operand selects go to the register file now
  always_comb begin
    for (int s = 0; s < 8; s++) begin
      dc_dec[s] = epp_decode(dc_pkt_reg[32*s +: 32]); // RULE6
      dc_nop[s] = (dc_dec[s].op == op_nop);
      core.rd_addr[2*s] = dc_dec[s].src1;
      core.rd_addr[2*s+1] = dc_dec[s].src2;
    end
  end

  // ==========================================================
  // Execute state
  logic [7:0] e1_vld_reg, e1_vld_next;
  epp_dec_t e1_dec_reg [8];
  epp_dec_t e1_dec_next [8];
  logic [7:0] e2_mwe_reg, e2_mwe_next, e2_msat_reg, e2_msat_next;
  logic [31:0] e2_prod_reg [8];
  logic [31:0] e2_prod_next [8];
  logic [3:0] e2_mdst_reg [8];
  logic [3:0] e2_mdst_next [8];
  logic sat2_reg, sat2_next, e3_msat_reg, e3_msat_next;
  logic sat_reg, sat_next;
  logic dmem_rd_reg, dmem_rd_next, dmem_wr_reg, dmem_wr_next;
  logic [31:0] dmem_addr_reg, dmem_addr_next;
  logic [31:0] dmem_wdata_reg, dmem_wdata_next;
  epp_ld_t ld_reg [2:5];
  epp_ld_t ld_next [2:5];
  logic [31:0] ld5_data_reg, ld5_data_next, mem_ea;
  logic mem_go;

  function automatic logic cond_ok(input epp_dec_t d,
                                   input logic [7:0] nz);
    if (d.cond == 3'h0) begin
      return 1'b1;
    end
    return d.zero_test ? !nz[d.cond] : nz[d.cond];
  endfunction : cond_ok

  // Execute phases; no interlock ever stalls issue
  always_comb begin // RULE22
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] ea;
    logic [32:0] r;
    logic go;
    a = '0;
    b = '0;
    ea = '0;
    r = '0;
    go = 1'b0;
    mem_go = 1'b0;
    mem_ea = '0;
    br_take = 1'b0;
    br_target = pc_reg;
    e1_vld_next = dc_vld_reg;
    e1_dec_next = dc_dec;
    sat2_next = 1'b0;
    e3_msat_next = |e2_msat_reg; // RULE18
    dmem_rd_next = 1'b0;
    dmem_wr_next = 1'b0;
    dmem_addr_next = dmem_addr_reg;
    dmem_wdata_next = dmem_wdata_reg;
    ld_next[2] = '0;
    ld_next[3] = ld_reg[2]; // RULE8 RULE17
    ld_next[4] = ld_reg[3];
    ld_next[5] = ld_reg[4];
    ld5_data_next = ld_reg[4].vld ? dmem_rdata_in : ld5_data_reg; // RULE19
    for (int s = 0; s < 8; s++) begin
      a = core.rd_data[2*s]; // RULE10
      b = core.rd_data[2*s+1];
      go = e1_vld_reg[s] && cond_ok(e1_dec_reg[s], core.nz); // RULE10 RULE20
      ea = epp_offset(a, e1_dec_reg[s].imm);
      core.we[s] = 1'b0;
      core.wa[s] = e1_dec_reg[s].dst;
      core.wd[s] = '0;
      e2_mwe_next[s] = 1'b0;
      e2_msat_next[s] = 1'b0;
      e2_prod_next[s] = '0;
      e2_mdst_next[s] = e1_dec_reg[s].dst;
      unique case (e1_dec_reg[s].op)
        op_nop: begin
        end
        op_add, op_sadd: begin
          r = epp_add(a, b, e1_dec_reg[s].op == op_sadd);
          core.we[s] = go; // RULE13
          core.wd[s] = r[31:0];
          sat2_next = sat2_next || (go && r[32]); // RULE15
        end
        op_mpy, op_smpy: begin
          r = epp_mul(a, b, e1_dec_reg[s].op == op_smpy);
          e2_mwe_next[s] = go; // RULE16
          e2_prod_next[s] = r[31:0];
          e2_msat_next[s] = go && r[32];
        end
        op_load, op_store: begin
          if (go && e1_dec_reg[s].ptr_mod) begin
            core.we[s] = 1'b1; // RULE11
            core.wa[s] = e1_dec_reg[s].src1;
            core.wd[s] = ea;
          end
          if (go && !mem_go) begin
            // One data port: lowest lane wins
            mem_go = 1'b1;
            mem_ea = ea;
            dmem_rd_next = (e1_dec_reg[s].op == op_load); // RULE14
            dmem_wr_next = (e1_dec_reg[s].op == op_store);
            dmem_addr_next = ea;
            dmem_wdata_next = b;
            ld_next[2] = '{vld: e1_dec_reg[s].op == op_load,
              dst: e1_dec_reg[s].dst, lane: 3'(s)};
          end
        end
        op_branch: begin
          if (go && !br_take) begin
            br_take = 1'b1; // RULE12
            br_target = ea & `EPP_PKT_ALIGN;
          end
        end
      endcase
      // Later phases win the lane's write port; clashes are software's
      if (e2_mwe_reg[s]) begin
        core.we[s] = 1'b1; // RULE16
        core.wa[s] = e2_mdst_reg[s];
        core.wd[s] = e2_prod_reg[s];
      end
      if (ld_reg[5].vld && ld_reg[5].lane == 3'(s)) begin
        core.we[s] = 1'b1; // RULE19
        core.wa[s] = ld_reg[5].dst;
        core.wd[s] = ld5_data_reg;
      end
    end
    // Hardware set wins over a clear in the same cycle
    sat_next = sat2_reg || e3_msat_reg || // RULE15 RULE18
      (sat_reg && !sat_clear_in);
  end

  // Execute registers
  always_ff @(posedge mclk_in or negedge rst_n_in) begin // RULE21
    if (!rst_n_in) begin
      e1_vld_reg <= '0; // RULE25
      e1_dec_reg <= '{default: '0};
      e2_mwe_reg <= '0;
      e2_msat_reg <= '0;
      e2_prod_reg <= '{default: '0};
      e2_mdst_reg <= '{default: '0};
      sat2_reg <= 1'b0;
      e3_msat_reg <= 1'b0;
      sat_reg <= `EPP_SAT_RESET;
      dmem_rd_reg <= 1'b0;
      dmem_wr_reg <= 1'b0;
      dmem_addr_reg <= '0;
      dmem_wdata_reg <= '0;
      ld_reg <= '{default: '0};
      ld5_data_reg <= '0;
    end else begin
      e1_vld_reg <= e1_vld_next;
      e1_dec_reg <= e1_dec_next;
      e2_mwe_reg <= e2_mwe_next;
      e2_msat_reg <= e2_msat_next;
      e2_prod_reg <= e2_prod_next;
      e2_mdst_reg <= e2_mdst_next;
      sat2_reg <= sat2_next;
      e3_msat_reg <= e3_msat_next;
      sat_reg <= sat_next;
      dmem_rd_reg <= dmem_rd_next;
      dmem_wr_reg <= dmem_wr_next;
      dmem_addr_reg <= dmem_addr_next;
      dmem_wdata_reg <= dmem_wdata_next;
      ld_reg <= ld_next;
      ld5_data_reg <= ld5_data_next;
    end
  end

  // Outputs straight from flip-flops
  assign prog_addr_out = ps_addr_reg;
  assign prog_req_out = ps_vld_reg;
  assign dmem_addr_out = dmem_addr_reg;
  assign dmem_wdata_out = dmem_wdata_reg;
  assign dmem_rd_out = dmem_rd_reg;
  assign dmem_wr_out = dmem_wr_reg;
  assign sat_flag_out = sat_reg;
  assign e1_issue_out = e1_vld_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  a_addr_send: assert property (pg_vld_reg && !hold |=> // RULE3
    prog_req_out && prog_addr_out == $past(pg_addr))
    else $error("fetch address not sent after generate");
  a_pkt_receive: assert property ( // RULE2
    pw_vld_reg && pw_fresh_reg && !hold |=>
    pr_vld_reg && pr_pkt_reg == $past(prog_data_in))
    else $error("fetch packet not received whole");
  a_fetch_decode: assert property ($rose(pg_vld_reg) |-> // RULE1
    ##4 dp_vld_reg)
    else $error("first packet not in dispatch four cycles on");
  a_reset_empty: assert property ($rose(pg_vld_reg) |-> // RULE25
    (e1_vld_reg == 8'h00) [*6])
    else $error("execute activity before first packet decoded");
  a_hold_fetch: assert property (hold |=> // RULE24
    $stable(prog_addr_out) && $stable(pr_pkt_reg))
    else $error("fetch moved while dispatch busy");
  a_nop_unrouted: assert property ((dc_vld_reg & dc_nop) == 8'h00) // RULE7
    else $error("no-operation routed to a unit");
  a_route_masked: assert property (dp_vld_reg |=> // RULE5
    (dc_vld_reg & ~$past(core.ep_mask)) == 8'h00)
    else $error("unit routed outside the dispatched packet");
  a_branch_redirect: assert property (br_take && !hold |=> // RULE12
    prog_addr_out == $past(br_target))
    else $error("branch did not redirect generate phase");
  a_mem_send: assert property (mem_go |=> // RULE14
    (dmem_rd_out ^ dmem_wr_out) && dmem_addr_out == $past(mem_ea))
    else $error("memory address not sent in second phase");
  a_false_quiet: assert property (!mem_go |=> // RULE20
    !dmem_rd_out && !dmem_wr_out)
    else $error("memory access without a true condition");
  a_load_write: assert property (dmem_rd_out |-> // RULE19
    ##3 (ld_reg[5].vld && core.we[ld_reg[5].lane]))
    else $error("load data not written in fifth phase");
  a_sat_single: assert property (sat2_next |-> ##2 sat_flag_out) // RULE15
    else $error("single-cycle saturation flag late or lost");
  a_mpy_write: assert property (e2_mwe_next != 8'h00 |=> // RULE16
    (core.we & $past(e2_mwe_next)) == $past(e2_mwe_next))
    else $error("multiply result not written in second phase");

  c_branch: cover property (br_take);
  c_multi_packet: cover property (hold ##1 !hold);
  c_load_done: cover property (ld_reg[5].vld);
  c_saturate: cover property ($rose(sat_flag_out));
endmodule : epp_pipeline

// *** hw/epp_regfile.sv ***
`timescale 1ns/1ps
module epp_regfile (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Core side
  epp_core_if.rf bus
);
  logic [31:0] mem_reg [16];
  logic [31:0] mem_next [16];
  logic [31:0] rd_reg [16];
  logic [31:0] rd_next [16];
  logic [7:0] nz_reg;
  logic [7:0] nz_next;

  // ==========================================================
  // Writes, then reads see this edge's writes (bypass)
  always_comb begin
    mem_next = mem_reg;
    for (int w = 0; w < 8; w++) begin
      if (bus.we[w]) begin
        mem_next[bus.wa[w]] = bus.wd[w]; // Higher lane wins a clash
      end
    end
    for (int r = 0; r < 16; r++) begin
      rd_next[r] = mem_next[bus.rd_addr[r]];
    end
    for (int c = 0; c < 8; c++) begin
      nz_next[c] = |mem_next[c];
    end
  end

  // Storage and registered read data
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mem_reg <= '{default: '0};
      rd_reg <= '{default: '0};
      nz_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      rd_reg <= rd_next;
      nz_reg <= nz_next;
    end
  end

  assign bus.rd_data = rd_reg;
  assign bus.nz = nz_reg;
endmodule : epp_regfile

// *** pkg/epp_cfg.svh ***
`ifndef EPP_CFG_SVH
`define EPP_CFG_SVH
// ==========================================================
// Fetch addressing
`define EPP_RESET_PC 32'h0000_0000
`define EPP_PKT_STEP 32'h0000_0020
`define EPP_PKT_ALIGN 32'hFFFF_FFE0
// ==========================================================
// Instruction word fields
`define EPP_F_COND 31:29
`define EPP_F_ZERO 28
`define EPP_F_DST 27:24
`define EPP_F_SRC1 23:20
`define EPP_F_SRC2 19:16
`define EPP_F_OP 15:13
`define EPP_F_IMM 12:2
`define EPP_F_PMOD 1
`define EPP_F_PAR 0
// ==========================================================
// Saturation
`define EPP_SAT_RESET 1'b0
`define EPP_SAT_MAX 32'h7FFF_FFFF
`define EPP_SAT_MIN 32'h8000_0000
`define EPP_SMPY_EDGE 16'h8000
`endif

// *** pkg/epp_core_if.sv ***
`timescale 1ns/1ps
interface epp_core_if;
  // Register file ports, two reads per lane
  logic [3:0] rd_addr [16];
  logic [31:0] rd_data [16];
  logic [7:0] we;
  logic [3:0] wa [8];
  logic [31:0] wd [8];
  logic [7:0] nz;
  // Dispatch split of the fetch packet
  logic [255:0] pkt;
  logic [2:0] start;
  logic [7:0] ep_mask;
  logic [7:0] route;
  logic ep_last;
  logic [2:0] next_start;
  modport rf (input rd_addr, we, wa, wd, output rd_data, nz);
  modport disp (input pkt, start, output ep_mask, route, ep_last,
    next_start);
endinterface : epp_core_if

// *** pkg/epp_pkg.sv ***
package epp_pkg;
`include "epp_cfg.svh"
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    op_nop, op_add, op_sadd, op_mpy, op_smpy, op_load, op_store, op_branch
  } epp_op_t;
  typedef struct packed {
    logic [2:0] cond;
    logic zero_test;
    logic [3:0] dst;
    logic [3:0] src1;
    logic [3:0] src2;
    epp_op_t op;
    logic [10:0] imm;
    logic ptr_mod;
  } epp_dec_t;
  typedef struct packed {
    logic vld;
    logic [3:0] dst;
    logic [2:0] lane;
  } epp_ld_t;
  // ==========================================================
  // Helpers
  function automatic epp_dec_t epp_decode(input logic [31:0] w);
    epp_dec_t d;
    d.cond = w[`EPP_F_COND];
    d.zero_test = w[`EPP_F_ZERO];
    d.dst = w[`EPP_F_DST];
    d.src1 = w[`EPP_F_SRC1];
    d.src2 = w[`EPP_F_SRC2];
    d.op = epp_op_t'(w[`EPP_F_OP]);
    d.imm = w[`EPP_F_IMM];
    d.ptr_mod = w[`EPP_F_PMOD];
    return d;
  endfunction : epp_decode
  function automatic logic [31:0] epp_offset(input logic [31:0] base,
                                             input logic [10:0] imm);
    return base + {{21{imm[10]}}, imm};
  endfunction : epp_offset
  // Returns {saturated, result}
  function automatic logic [32:0] epp_add(input logic [31:0] a,
                                          input logic [31:0] b,
                                          input logic saturation_flag);
    logic [32:0] s;
    logic ovf;
    s = {a[31], a} + {b[31], b};
    ovf = saturation_flag && (s[32] ^ s[31]);
    if (ovf) begin
      return {1'b1, s[32] ? `EPP_SAT_MIN : `EPP_SAT_MAX};
    end
    return {1'b0, s[31:0]};
  endfunction : epp_add
  function automatic logic [32:0] epp_mul(input logic [31:0] a,
                                          input logic [31:0] b,
                                          input logic saturation_flag);
    logic signed [31:0] p;
    p = $signed(a[15:0]) * $signed(b[15:0]);
    if (!saturation_flag) begin
      return {1'b0, p};
    end
    if (a[15:0] == `EPP_SMPY_EDGE && b[15:0] == `EPP_SMPY_EDGE) begin
      return {1'b1, `EPP_SAT_MAX};
    end
    return {1'b0, p[30:0], 1'b0};
  endfunction : epp_mul
endpackage : epp_pkg
